// File: core/alm_conv_timer.sv
// Conversion duration timer for one shunt or bus conversion
`timescale 1ns/1ps
module alm_conv_timer #(
  parameter int unsigned CT_CYCLES [8] = alm_pkg::ALM_CT_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [2:0] sel_in,
  output logic done_out
);
  import alm_pkg::*;

  alm_tmr_t r;
  alm_tmr_t n;

  // ****************************************
  // Parameter check
  // ****************************************
  for (genvar i = 0; i < 8; i++) begin : g_chk
    if (CT_CYCLES[i] < 2 || CT_CYCLES[i] >= (1 << ALM_CNT_W)) begin : g_bad
      $error("conversion cycle count out of range");
    end
  end

  // ****************************************
  // Countdown
  // ****************************************
  always_comb begin
    n = r;
    n.done = 1'b0;
    // Selected duration
    if (start_in) begin
      n.busy = 1'b1;
      n.cnt = ALM_CNT_W'(CT_CYCLES[sel_in] - 1);
    end else if (r.busy) begin
      if (r.cnt == '0) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.cnt = r.cnt - ALM_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign done_out = r.done;

  property p_done_pulse;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      r.done |=> !r.done && !r.busy;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("timer done not a single pulse");

endmodule

// File: core/alm_monitor.sv
// Averaging, register file and limit alert logic of the monitor
`timescale 1ns/1ps
module alm_monitor #(
  parameter int unsigned CT_CYCLES [8] = alm_pkg::ALM_CT_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire alm_pkg::alm_reg_req_t reg_req_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire alm_pkg::alm_meas_t meas_in,
  output logic conv_shunt_out,
  output logic conv_bus_out,
  output logic alert_out,
  output logic alert_oe_out
);
  import alm_pkg::*;

  alm_mon_t r;
  alm_mon_t n;
  logic tmr_done;
  logic [2:0] tmr_sel;
  logic [4:0] fn;
  logic cfg_wr;
  logic cfg_go;
  logic mask_rd;
  logic load_evt;
  logic chk_evt;
  logic viol;
  logic alert_lvl;

  // ****************************************
  // Conversion timer
  // ****************************************
  // Separate shunt and bus duration fields
  // per phase select
  assign tmr_sel = (r.state == ALM_SHUNT) ? r.cfg[ALM_SCT_LSB +: 3]
                                          : r.cfg[ALM_BCT_LSB +: 3];

  alm_conv_timer #(
    .CT_CYCLES(CT_CYCLES)
  ) u_timer (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(r.tmr_start),
    .sel_in(tmr_sel),
    .done_out(tmr_done)
  );

  // ****************************************
  // Function select
  // ****************************************
  // highest bit wins
  always_comb begin
    fn = 5'h00;
    if (r.mask_en[ALM_MB_SOL]) begin
      fn[4] = 1'b1;
    end else if (r.mask_en[ALM_MB_SUL]) begin
      fn[3] = 1'b1;
    end else if (r.mask_en[ALM_MB_BOL]) begin
      fn[2] = 1'b1;
    end else if (r.mask_en[ALM_MB_BUL]) begin
      fn[1] = 1'b1;
    end else if (r.mask_en[ALM_MB_POL]) begin
      fn[0] = 1'b1;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [ALM_ACC_W-1:0] a_sh;
    logic [ALM_ACC_W-1:0] a_bu;
    logic [ALM_ACC_W-1:0] a_pw;
    logic [ALM_ACC_W-1:0] a_cu;
    logic signed [ALM_ACC_W-1:0] avg_sh;
    logic signed [ALM_ACC_W-1:0] avg_cu;
    logic [ALM_ACC_W-1:0] avg_bu;
    logic [ALM_ACC_W-1:0] avg_pw;
    logic [3:0] shift;
    logic [ALM_SMP_W-1:0] cnt_inc;
    logic [15:0] mrd;
    logic end_smp;
    logic restart;
    a_sh = r.acc_shunt;
    a_bu = r.acc_bus;
    a_pw = r.acc_power;
    a_cu = r.acc_current;
    avg_sh = '0;
    avg_cu = '0;
    avg_bu = '0;
    avg_pw = '0;
    shift = ALM_AVG_SHIFT[r.cfg[ALM_AVG_LSB +: 3]];
    cnt_inc = r.smp_cnt + ALM_SMP_W'(1);
    mrd = r.mask_en;
    end_smp = 1'b0;
    restart = 1'b0;
    cfg_wr = reg_req_in.wr && reg_req_in.addr == ALM_ADDR_CFG;
    cfg_go = cfg_wr && (reg_req_in.wdata[ALM_MODE_SHUNT]
                        || reg_req_in.wdata[ALM_MODE_BUS]);
    mask_rd = reg_req_in.rd && reg_req_in.addr == ALM_ADDR_MASK;
    load_evt = 1'b0;
    chk_evt = 1'b0;
    viol = 1'b0;
    n = r;
    n.tmr_start = 1'b0;
    n.rvalid = 1'b0;
    n.boot = 1'b0;
    // Start from the reset mode once
    if (r.boot) begin
      restart = r.cfg[ALM_MODE_SHUNT] || r.cfg[ALM_MODE_BUS];
    end

    // Register writes
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        ALM_ADDR_CFG: begin
          n.cfg = reg_req_in.wdata;
          n.state = ALM_IDLE;
          n.acc_shunt = '0;
          n.acc_bus = '0;
          n.acc_power = '0;
          n.acc_current = '0;
          n.smp_cnt = '0;
          if (cfg_go) begin
            restart = 1'b1;
            n.conversion_done_flag = 1'b0;
          end
          if (r.mask_en[ALM_MB_LEN]) begin
            n.aff = 1'b0;
          end
        end
        ALM_ADDR_MASK: n.mask_en = reg_req_in.wdata & ALM_MASK_WR;
        ALM_ADDR_LIMIT: n.limit = reg_req_in.wdata;
        default: ;
      endcase
    end

    // Register reads
    if (reg_req_in.rd) begin
      n.rvalid = 1'b1;
      mrd[ALM_MB_AFF] = r.aff;
      mrd[ALM_MB_CONVERSION_DONE_FLAG] = r.conversion_done_flag;
      unique case (reg_req_in.addr)
        ALM_ADDR_CFG: n.rdata = r.cfg;
        ALM_ADDR_SHUNT: n.rdata = r.res_shunt;
        ALM_ADDR_BUS: n.rdata = r.res_bus;
        ALM_ADDR_POWER: n.rdata = r.res_power;
        ALM_ADDR_CURRENT: n.rdata = r.res_current;
        ALM_ADDR_MASK: n.rdata = mrd;
        ALM_ADDR_LIMIT: n.rdata = r.limit;
        default: n.rdata = 16'h0000;
      endcase
      if (mask_rd) begin
        n.conversion_done_flag = 1'b0;
        if (r.mask_en[ALM_MB_LEN]) begin
          n.aff = 1'b0;
        end
      end
    end

    // Conversion ends; a result racing a config write is dropped
    // Done seen while a start is pending is stale from an aborted run
    if (tmr_done && !cfg_wr && !r.tmr_start) begin
      if (r.state == ALM_SHUNT) begin
        a_sh = r.acc_shunt + {{10{meas_in.shunt[15]}}, meas_in.shunt};
        a_cu = r.acc_current + {{10{meas_in.current[15]}}, meas_in.current};
        n.acc_shunt = a_sh;
        n.acc_current = a_cu;
        chk_evt = fn[4] || fn[3];
        viol = (fn[4] && $signed(meas_in.shunt) > $signed(r.limit))
            || (fn[3] && $signed(meas_in.shunt) < $signed(r.limit));
        if (r.cfg[ALM_MODE_BUS]) begin
          n.state = ALM_BUS;
          n.tmr_start = 1'b1;
        end else begin
          end_smp = 1'b1;
        end
      end else if (r.state == ALM_BUS) begin
        a_bu = r.acc_bus + {10'h000, meas_in.bus};
        a_pw = r.acc_power + {10'h000, meas_in.power};
        n.acc_bus = a_bu;
        n.acc_power = a_pw;
        chk_evt = fn[2] || fn[1] || fn[0];
        viol = (fn[2] && meas_in.bus > r.limit)
            || (fn[1] && meas_in.bus < r.limit)
            || (fn[0] && meas_in.power > r.limit);
        end_smp = 1'b1;
      end
    end

    if (chk_evt) begin
      n.aff = r.mask_en[ALM_MB_LEN] ? (n.aff || viol) : viol;
    end

    if (end_smp) begin
      if (cnt_inc == (ALM_SMP_W'(1) << shift)) begin
        load_evt = 1'b1;
        avg_sh = $signed(a_sh) >>> shift;
        avg_cu = $signed(a_cu) >>> shift;
        avg_bu = a_bu >> shift;
        avg_pw = a_pw >> shift;
        n.res_shunt = avg_sh[15:0];
        n.res_current = avg_cu[15:0];
        n.res_bus = avg_bu[15:0];
        n.res_power = avg_pw[15:0];
        n.acc_shunt = '0;
        n.acc_bus = '0;
        n.acc_power = '0;
        n.acc_current = '0;
        n.smp_cnt = '0;
        n.conversion_done_flag = 1'b1;
        n.state = ALM_IDLE;
        restart = r.cfg[ALM_MODE_CONT];
      end else begin
        n.smp_cnt = cnt_inc;
        restart = 1'b1;
      end
    end

    // Shunt first when enabled, else bus only
    if (restart) begin
      n.state = n.cfg[ALM_MODE_SHUNT] ? ALM_SHUNT : ALM_BUS;
      n.tmr_start = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r <= ALM_MON_RESET;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // ready only when routed
  assign alert_lvl = r.aff || (r.mask_en[ALM_MB_READY_TO_PIN_ENABLE] && r.conversion_done_flag);
  assign alert_out = 1'b0;
  assign alert_oe_out = alert_lvl ^ r.mask_en[ALM_MB_PIN_POLARITY_SELECT];
  assign reg_rdata_out = r.rdata;
  assign reg_rvalid_out = r.rvalid;
  assign conv_shunt_out = r.state == ALM_SHUNT;
  assign conv_bus_out = r.state == ALM_BUS;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_load;
    load_evt;
  endsequence

  sequence s_cfg_go;
    cfg_go ##1 r.tmr_start;
  endsequence

  property p_load_ready;
    s_load |=> r.conversion_done_flag && r.smp_cnt == '0;
  endproperty
  a_load_ready: assert property (p_load_ready)
    else $error("ready not set after average load");

  property p_res_hold;
    !load_evt |=> $stable(r.res_shunt) && $stable(r.res_power);
  endproperty
  a_res_hold: assert property (p_res_hold)
    else $error("result changed without a load");

  property p_trigger;
    cfg_go |-> s_cfg_go;
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("config write did not start conversion");

  property p_ready_clear;
    mask_rd && !load_evt |=> !r.conversion_done_flag;
  endproperty
  a_ready_clear: assert property (p_ready_clear)
    else $error("status read left ready set");

  property p_latch_hold;
    r.mask_en[ALM_MB_LEN] && r.aff && !cfg_wr && !mask_rd |=> r.aff;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched flag dropped");

  property p_hit;
    chk_evt && viol |=> r.aff ##0 alert_lvl;
  endproperty
  a_hit: assert property (p_hit)
    else $error("violation did not set flag");

  property p_unlatched;
    chk_evt && !viol && !r.mask_en[ALM_MB_LEN] |=> !r.aff;
  endproperty
  a_unlatched: assert property (p_unlatched)
    else $error("unlatched flag did not clear");

  property p_power;
    tmr_done && r.state == ALM_BUS && fn[0] && !cfg_wr && !r.tmr_start
      && meas_in.power > r.limit |=> r.aff;
  endproperty
  a_power: assert property (p_power)
    else $error("power over limit missed");

  property p_quiet;
    !r.mask_en[ALM_MB_READY_TO_PIN_ENABLE] && !r.aff
      |-> alert_oe_out == r.mask_en[ALM_MB_PIN_POLARITY_SELECT];
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("alert asserted without limit hit");

  property p_prio;
    r.mask_en[ALM_MB_SOL] |-> fn == 5'h10;
  endproperty
  a_prio: assert property (p_prio)
    else $error("lower function not ignored");

endmodule

// File: core/alm_pkg.sv
// Constants and types for the alert limit monitor
// Functional notes
// - Load averages after the final sample.
// - Conversion times span 140 us to 8.244 ms.
// - Shunt, bus times and averaging set separately.
// - Update interval is times summed, times count.
// - One threshold register at offset 07h.
// - Five alert functions, one enable bit each.
// - Open-drain alert asserts on threshold violation.
// - Highest enabled function bit alone is monitored.
// - Ready routing clear: alert only on limits.
// - Shunt limits checked after every shunt conversion.
// - Limit hit flag D4 set on violation.
// - Polarity bit D1 picks alert active level.
// - Latched flag holds until config write, status read.
// - Bus limits checked after every bus conversion.
// - Power limit checked after every bus conversion.
// - Compare single conversions, never the averages.
// - Done flag sets per cycle, clears on a config write that starts a conversion, or on a status read.
// - Mode 111 continuous; 001-011 one shot per write.
package alm_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned ALM_CLK_NS = 8;
  localparam int unsigned ALM_CT_NS [8] = '{140_000, 204_000, 332_000,
    588_000, 1_100_000, 2_116_000, 4_156_000, 8_244_000};
  localparam int unsigned ALM_CT_CYC [8] = '{
    ALM_CT_NS[0] / ALM_CLK_NS, ALM_CT_NS[1] / ALM_CLK_NS,
    ALM_CT_NS[2] / ALM_CLK_NS, ALM_CT_NS[3] / ALM_CLK_NS,
    ALM_CT_NS[4] / ALM_CLK_NS, ALM_CT_NS[5] / ALM_CLK_NS,
    ALM_CT_NS[6] / ALM_CLK_NS, ALM_CT_NS[7] / ALM_CLK_NS};
  localparam int unsigned ALM_CNT_W = 21;
  // Averages 1,4,16,64,128,256,512,1024 as shift amounts
  localparam logic [3:0] ALM_AVG_SHIFT [8] = '{4'h0, 4'h2, 4'h4, 4'h6,
    4'h7, 4'h8, 4'h9, 4'ha};
  localparam int unsigned ALM_ACC_W = 26;
  localparam int unsigned ALM_SMP_W = 11;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ALM_ADDR_CFG = 8'h00;
  localparam logic [7:0] ALM_ADDR_SHUNT = 8'h01;
  localparam logic [7:0] ALM_ADDR_BUS = 8'h02;
  localparam logic [7:0] ALM_ADDR_POWER = 8'h03;
  localparam logic [7:0] ALM_ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ALM_ADDR_MASK = 8'h06;
  localparam logic [7:0] ALM_ADDR_LIMIT = 8'h07;
  localparam logic [15:0] ALM_CFG_RESET = 16'h4127;
  localparam logic [15:0] ALM_MASK_WR = 16'hfc03;
  localparam int unsigned ALM_MODE_SHUNT = 0;
  localparam int unsigned ALM_MODE_BUS = 1;
  localparam int unsigned ALM_MODE_CONT = 2;
  localparam int unsigned ALM_SCT_LSB = 3;
  localparam int unsigned ALM_BCT_LSB = 6;
  localparam int unsigned ALM_AVG_LSB = 9;
  localparam int unsigned ALM_MB_SOL = 15;
  localparam int unsigned ALM_MB_SUL = 14;
  localparam int unsigned ALM_MB_BOL = 13;
  localparam int unsigned ALM_MB_BUL = 12;
  localparam int unsigned ALM_MB_POL = 11;
  localparam int unsigned ALM_MB_READY_TO_PIN_ENABLE = 10;
  localparam int unsigned ALM_MB_AFF = 4;
  localparam int unsigned ALM_MB_CONVERSION_DONE_FLAG = 3;
  localparam int unsigned ALM_MB_PIN_POLARITY_SELECT = 1;
  localparam int unsigned ALM_MB_LEN = 0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ALM_IDLE = 3'h1,
    ALM_SHUNT = 3'h2,
    ALM_BUS = 3'h4
  } alm_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } alm_reg_req_t;

  typedef struct packed {
    logic [15:0] shunt;
    logic [15:0] bus;
    logic [15:0] current;
    logic [15:0] power;
  } alm_meas_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [ALM_CNT_W-1:0] cnt;
  } alm_tmr_t;

  typedef struct packed {
    alm_state_t state;
    logic boot;
    logic tmr_start;
    logic [15:0] cfg;
    logic [15:0] mask_en;
    logic [15:0] limit;
    logic [15:0] res_shunt;
    logic [15:0] res_bus;
    logic [15:0] res_power;
    logic [15:0] res_current;
    logic [ALM_ACC_W-1:0] acc_shunt;
    logic [ALM_ACC_W-1:0] acc_bus;
    logic [ALM_ACC_W-1:0] acc_power;
    logic [ALM_ACC_W-1:0] acc_current;
    logic [ALM_SMP_W-1:0] smp_cnt;
    logic aff;
    logic conversion_done_flag;
    logic rvalid;
    logic [15:0] rdata;
  } alm_mon_t;

  localparam alm_mon_t ALM_MON_RESET = '{state: ALM_IDLE, boot: 1'b1,
    cfg: ALM_CFG_RESET, default: '0};

endpackage

// File: verification/alert_limit_monitor_tb.sv
// Self-checking bench for the alert limit monitor
`timescale 1ns/1ps
module alert_limit_monitor_tb;
  import alm_pkg::*;
  // Short conversion counts keep the run brief
  localparam int unsigned CT [8] = '{2, 3, 4, 5, 6, 7, 8, 9};
  logic sys_clk_in;
  logic rst_n_in;
  alm_reg_req_t req;
  logic [15:0] rdata;
  logic rvalid;
  alm_meas_t meas;
  alm_meas_t base;
  logic alt;
  logic cs;
  logic cb;
  logic alert;
  logic oe;
  int bad_count;
  int total_checks;

  alm_monitor #(.CT_CYCLES(CT)) dut_u (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .reg_req_in(req),
    .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid),
    .meas_in(meas),
    .conv_shunt_out(cs),
    .conv_bus_out(cb),
    .alert_out(alert),
    .alert_oe_out(oe)
  );

  alm_front_model fe_u (
    .sys_clk_in(sys_clk_in),
    .conv_shunt_in(cs),
    .conv_bus_in(cb),
    .alt_in(alt),
    .base_in(base),
    .meas_out(meas)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  // ********
  // Helpers
  // ********
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic timeout();
    bad_count++;
    conclude();
  endtask

  // Inputs always change 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask

  // Idle cycle after each strobe avoids double drives
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    tick(1);
    req.wr = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int i;
    req.rd = 1'b1;
    req.addr = a;
    tick(1);
    req.rd = 1'b0;
    i = 0;
    while (rvalid !== 1'b1 && i < 3) begin
      tick(1);
      i++;
    end
    if (i == 3) timeout();
    d = rdata;
    tick(1);
  endtask

  task automatic wait_bus(input int n);
    int i;
    for (int k = 0; k < n; k++) begin
      i = 0;
      while (cb !== 1'b1 && i < 200) begin
        tick(1);
        i++;
      end
      while (cb !== 1'b0 && i < 200) begin
        tick(1);
        i++;
      end
      if (i >= 200) timeout();
    end
    tick(2);
  endtask

  task automatic set_q(input int k, input logic [15:0] v);
    base = '{default: 16'h0100};
    if (k == 0) base.shunt = v;
    if (k == 1) base.bus = v;
    if (k == 2) base.power = v;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic s_regs();
    logic [15:0] d;
    rd(ALM_ADDR_CFG, d);
    check(d, 16'h4127);
    wr(ALM_ADDR_LIMIT, 16'h1234);
    rd(ALM_ADDR_LIMIT, d);
    check(d, 16'h1234);
    rd(8'h08, d);
    check(d, 16'h0000);
    wr(ALM_ADDR_MASK, 16'hffff);
    rd(ALM_ADDR_MASK, d);
    check(d & 16'hffe7, 16'hfc03);
  endtask

  task automatic s_timing();
    int n, hs, rs, a, b;
    logic ps;
    logic [15:0] d;
    base = '{default: 16'h0100};
    alt = 1'b1;
    wr(ALM_ADDR_MASK, 16'h0400);
    for (int s = 0; s < 8; s++) begin
      a = CT[s];
      b = CT[7 - s];
      wr(ALM_ADDR_CFG, 16'h0000);
      wr(ALM_ADDR_CFG, {7'h01, 3'(7 - s), 3'(s), 3'h7});
      n = 0;
      hs = 0;
      rs = 0;
      ps = 1'b0;
      while (oe !== 1'b1 && n < 400) begin
        hs += (cs === 1'b1);
        rs += (cs === 1'b1 && ps !== 1'b1);
        ps = cs;
        tick(1);
        n++;
      end
      check(hs >= 4 * a && hs <= 4 * (a + 2), 1'b1);
      check(n >= 4 * (a + b + 1) && n <= 4 * (a + b + 4), 1'b1);
      check(16'(rs), 16'h0004);
      for (int k = 1; k < 5; k++) begin
        rd(8'(k), d);
        check(d, 16'h0108);
      end
    end
  endtask

  task automatic s_alerts();
    logic [15:0] fb [5] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
      16'h0800};
    int q [5] = '{0, 0, 1, 1, 2};
    // Negative shunt probes the signed compare
    logic [15:0] bv [5] = '{16'h0200, 16'hff00, 16'h0200, 16'h0080,
      16'h0200};
    logic [15:0] ov [5] = '{16'hff00, 16'h0200, 16'h0080, 16'h0200,
      16'h0080};
    logic [15:0] d;
    int hit;
    alt = 1'b0;
    wr(ALM_ADDR_LIMIT, 16'h0100);
    for (int f = 0; f < 5; f++) begin
      set_q(q[f], bv[f]);
      wr(ALM_ADDR_MASK, fb[f]);
      wr(ALM_ADDR_CFG, 16'h0127);
      wait_bus(2);
      check(oe, 1'b1);
      check(alert, 1'b0);
      rd(ALM_ADDR_MASK, d);
      check(d[4], 1'b1);
      set_q(q[f], ov[f]);
      wait_bus(2);
      check(oe, 1'b0);
    end
    set_q(0, 16'h0200);
    wr(ALM_ADDR_MASK, 16'h8002);
    wait_bus(1);
    check(oe, 1'b0);
    set_q(1, 16'h0200);
    wr(ALM_ADDR_MASK, 16'ha000);
    wait_bus(2);
    check(oe, 1'b0);
    set_q(0, 16'h0200);
    wait_bus(2);
    check(oe, 1'b1);
    base = '{default: 16'h0100};
    base.shunt = 16'h00f8;
    alt = 1'b1;
    wr(ALM_ADDR_MASK, 16'h8000);
    wr(ALM_ADDR_CFG, 16'h0327);
    hit = 0;
    repeat (120) begin
      hit += (oe === 1'b1);
      tick(1);
    end
    check(hit > 0, 1'b1);
    rd(ALM_ADDR_SHUNT, d);
    check(d, 16'h0100);
  endtask

  task automatic s_latch();
    logic [15:0] d;
    alt = 1'b0;
    set_q(0, 16'h0200);
    wr(ALM_ADDR_MASK, 16'h8001);
    wr(ALM_ADDR_CFG, 16'h0127);
    wait_bus(1);
    set_q(0, 16'h0100);
    wait_bus(2);
    check(oe, 1'b1);
    rd(ALM_ADDR_MASK, d);
    check(d[4], 1'b1);
    check(oe, 1'b0);
    set_q(0, 16'h0200);
    wait_bus(1);
    check(oe, 1'b1);
    set_q(0, 16'h0100);
    wr(ALM_ADDR_CFG, 16'h0127);
    check(oe, 1'b0);
  endtask

  task automatic s_single();
    logic [15:0] d;
    int rs, rb;
    logic ps, pb;
    set_q(0, 16'h0100);
    wr(ALM_ADDR_MASK, 16'h0400);
    for (int m = 1; m < 4; m++) begin
      wr(ALM_ADDR_CFG, 16'h0120);
      rd(ALM_ADDR_MASK, d);
      wr(ALM_ADDR_CFG, 16'h0120 | 16'(m));
      rs = 0;
      rb = 0;
      ps = 1'b0;
      pb = 1'b0;
      repeat (60) begin
        rs += (cs === 1'b1 && ps !== 1'b1);
        rb += (cb === 1'b1 && pb !== 1'b1);
        ps = cs;
        pb = cb;
        tick(1);
      end
      check(16'(rs), 16'(m & 1));
      check(16'(rb), 16'(m >> 1));
      check(oe, 1'b1);
    end
    wr(ALM_ADDR_CFG, 16'h0120);
    check(oe, 1'b1);
    rd(ALM_ADDR_MASK, d);
    check(d[3], 1'b1);
    check(oe, 1'b0);
  endtask

  initial begin
    rst_n_in = 1'b0;
    req = '0;
    base = '0;
    alt = 1'b0;
    bad_count = 0;
    total_checks = 0;
    tick(10);
    rst_n_in = 1'b1;
    tick(1);
    s_regs();
    s_timing();
    s_alerts();
    s_latch();
    s_single();
    conclude();
  end
endmodule

// File: verification/alm_front_model.sv
// Measurement front-end model that feeds the monitor
`timescale 1ns/1ps
module alm_front_model (
  input wire logic sys_clk_in,
  input wire logic conv_shunt_in,
  input wire logic conv_bus_in,
  input wire logic alt_in,
  input wire alm_pkg::alm_meas_t base_in,
  output alm_pkg::alm_meas_t meas_out
);
  import alm_pkg::*;
  logic sh_q = 1'b0;
  logic bu_q = 1'b0;
  logic ph_s = 1'b0;
  logic ph_b = 1'b0;
  logic [15:0] st_s;
  logic [15:0] st_b;
  // Step each result when its conv_shunt_in or conv_bus_in rises so averages differ
  always @(posedge sys_clk_in) begin
    sh_q <= conv_shunt_in;
    bu_q <= conv_bus_in;
    if (conv_shunt_in && !sh_q) ph_s <= ~ph_s;
    if (conv_bus_in && !bu_q) ph_b <= ~ph_b;
  end
  // Results hold like ADC output latches
  assign st_s = (alt_in && ph_s) ? 16'h0010 : 16'h0000;
  assign st_b = (alt_in && ph_b) ? 16'h0010 : 16'h0000;
  assign meas_out.shunt = base_in.shunt + st_s;
  assign meas_out.current = base_in.current + st_s;
  assign meas_out.bus = base_in.bus + st_b;
  assign meas_out.power = base_in.power + st_b;
endmodule
